// file: rtl/spi_port_pkg.sv
// shared constants and types for the serial port block
// assumes a single 100 MHz system clock and synchronous pin inputs
package spi_port_pkg;

   // -------------------------------------------------------------------
   // mode field codes
   // -------------------------------------------------------------------
   localparam logic [3:0] MODE_DIV4 = 4'h0;
   localparam logic [3:0] MODE_DIV16 = 4'h1;
   localparam logic [3:0] MODE_DIV64 = 4'h2;
   localparam logic [3:0] MODE_TIMER = 4'h3;
   localparam logic [3:0] MODE_SLAVE_SEL = 4'h4;
   localparam logic [3:0] MODE_SLAVE = 4'h5;
   localparam logic [3:0] MODE_BAUD = 4'ha;

   // -------------------------------------------------------------------
   // half serial clock period minus one, in system clocks
   // -------------------------------------------------------------------
   localparam logic [8:0] HALF_M1_DIV4 = 9'h001;
   localparam logic [8:0] HALF_M1_DIV16 = 9'h007;
   localparam logic [8:0] HALF_M1_DIV64 = 9'h01f;
   localparam logic [8:0] HALF_CNT_ZERO = 9'h000;

   // -------------------------------------------------------------------
   // byte framing
   // -------------------------------------------------------------------
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_ZERO = 3'h0;
   localparam logic [4:0] EDGE_LAST = 5'h10;
   localparam logic [4:0] EDGE_ZERO = 5'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // -------------------------------------------------------------------
   // register field positions
   // -------------------------------------------------------------------
   localparam int CTL_WRITE_COLLISION_FLAG = 7;
   localparam int CTL_OVFL = 6;
   localparam int CTL_EN = 5;
   localparam int CTL_CKP = 4;
   localparam int STA_SMP = 7;
   localparam int STA_CKE = 6;
   localparam logic [4:0] STA_RO_ZERO = 5'h00;

   // -------------------------------------------------------------------
   // master sequencer states
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      MST_IDLE = 2'b01,
      MST_RUN = 2'b10
   } mst_state_t;

endpackage

// file: rtl/spi_rate_gen.sv
// serial clock half-period tick generator for master mode
// assumes the timer match input is a one-cycle pulse on clk_sys_i
`timescale 1ns/1ps
`default_nettype none

module spi_rate_gen (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic [3:0] mode_i,
   input wire logic [7:0] baud_reload_value_i,
   input wire logic timer_match_i,
   output logic tick_o
);

   typedef struct packed {
      logic [8:0] cnt;
      logic tick;
   } rate_state_t;

   rate_state_t s_ff;
   rate_state_t nxt_s;
   logic [8:0] half_m1;

   // -------------------------------------------------------------------
   // divider
   // -------------------------------------------------------------------
   always_comb begin
      nxt_s = s_ff;
      unique case (mode_i)
         spi_port_pkg::MODE_DIV16: half_m1 = spi_port_pkg::HALF_M1_DIV16;
         spi_port_pkg::MODE_DIV64: half_m1 = spi_port_pkg::HALF_M1_DIV64;
         spi_port_pkg::MODE_BAUD: half_m1 = {baud_reload_value_i, 1'b1};
         default: half_m1 = spi_port_pkg::HALF_M1_DIV4;
      endcase
      nxt_s.tick = 1'b0;
      if (!run_i) begin
         nxt_s.cnt = spi_port_pkg::HALF_CNT_ZERO;
      end else if (mode_i == spi_port_pkg::MODE_TIMER) begin
         // each timer match is one half period, so the bit rate is half the match rate
         nxt_s.tick = timer_match_i;
      end else if (s_ff.cnt == half_m1) begin
         nxt_s.cnt = spi_port_pkg::HALF_CNT_ZERO;
         nxt_s.tick = 1'b1;
      end else begin
         nxt_s.cnt = s_ff.cnt + 9'h001;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign tick_o = s_ff.tick;

endmodule // spi_rate_gen

`default_nettype wire

// file: rtl/sync_serial_port.sv
// spi-mode serial port: shift register, receive buffer, flags and master clocking
// assumes pins are synchronous to clk_sys_i and the slave clock is far below it
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - eight-bit shifter, msb out first, incoming bit enters the lsb
// - data out changes on the programmed edge, input captured on the other edge
// - after eight clocks master and slave have swapped register contents
// - unselected slave ignores clock and data and does not drive data out
// - master drives no select lines; slave selection is left to software
// - full byte sets interrupt flag and, if buffer empty or overwrite on, copies into buffer and sets buffer-full; else overflow
// - transmit unbuffered: buffer write loads the shift register too
// - write during transfer is dropped and sets collision; blocked until cleared
// - reading the buffer clears buffer-full
// - enable turns port on; reconfigure by disabling, rewriting, re-enabling
// - master starts clocking a byte as soon as the buffer is written
// - master with data out disabled still receives and flags each byte
// - master rate: clock/4, /16, /64, timer/2, or clock/(4*(reload+1))
// - edge bit picks output edge; when set data valid before first edge
// - sample-phase bit picks master sampling at middle or end of data time; slave ignores it
// - slave shifts on external clock; interrupt flag set on last bit
// - slave keeps shifting from pin clock in sleep; byte raises interrupt
// - with overwrite enabled, buffer writes accepted though byte unread
// - daisy chain slave resends on second byte what it got on first
// - with nothing pending the master stops the clock; selects are left to software
// - status low six bits read-only, upper two read/write
// - select high in select mode or enable cleared zeroes the bit count
// - mode 0100 is select-controlled slave; data out driven only while selected
// - select rising stops driving data out on the next system clock, even mid-byte
module sync_serial_port (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic ctrl_wr_i,
   input wire logic [7:0] ctrl_wdata_i,
   input wire logic status_wr_i,
   input wire logic [7:0] status_wdata_i,
   input wire logic buf_wr_i,
   input wire logic [7:0] buf_wdata_i,
   input wire logic buf_rd_i,
   input wire logic irq_clr_i,
   input wire logic buffer_overwrite_enable_i,
   input wire logic [7:0] baud_reload_value_i,
   input wire logic timer_match_i,
   input wire logic sck_i,
   input wire logic sdi_i,
   input wire logic sel_n_i,
   output logic sck_o,
   output logic sck_oe_o,
   output logic sdo_o,
   output logic sdo_oe_o,
   output logic [7:0] port_control_one_o,
   output logic [7:0] port_status_reg_o,
   output logic [7:0] data_buffer_o,
   output logic port_interrupt_flag_o
);

   typedef struct packed {
      spi_port_pkg::mst_state_t mst;
      logic [7:0] shreg;
      logic [7:0] dbuf;
      logic [2:0] bits;
      logic [4:0] edges;
      logic sck;
      logic sck_oe;
      logic sdo;
      logic sdo_oe;
      logic sck_prev;
      logic full;
      logic irq;
      logic write_collision_flag;
      logic ovfl;
      logic en;
      logic clock_polarity_bit;
      logic [3:0] mode;
      logic sample_phase_bit;
      logic cke;
   } port_state_t;

   port_state_t s_ff;
   port_state_t nxt_s;
   logic tick;
   logic is_master;
   logic is_slave;
   logic selected;
   logic busy;
   logic edge_ev;
   logic lead;
   logic sample_edge;
   logic do_shift;
   logic byte_done;
   logic wr_ok;
   logic [4:0] edge_num;

   // -------------------------------------------------------------------
   // master bit clock
   // -------------------------------------------------------------------
   spi_rate_gen u_rate (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .run_i(s_ff.mst == spi_port_pkg::MST_RUN),
      .mode_i(s_ff.mode),
      .baud_reload_value_i(baud_reload_value_i),
      .timer_match_i(timer_match_i),
      .tick_o(tick)
   );

   // -------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------
   always_comb begin
      nxt_s = s_ff;
      is_master = s_ff.en && (s_ff.mode == spi_port_pkg::MODE_DIV4 ||
                              s_ff.mode == spi_port_pkg::MODE_DIV16 ||
                              s_ff.mode == spi_port_pkg::MODE_DIV64 ||
                              s_ff.mode == spi_port_pkg::MODE_TIMER ||
                              s_ff.mode == spi_port_pkg::MODE_BAUD);
      is_slave = s_ff.en && (s_ff.mode == spi_port_pkg::MODE_SLAVE_SEL ||
                             s_ff.mode == spi_port_pkg::MODE_SLAVE);
      // without select control the slave counts as always selected
      // one select line per port; the master side leaves selects to software
      selected = (s_ff.mode != spi_port_pkg::MODE_SLAVE_SEL) || !sel_n_i;
      busy = (s_ff.mst == spi_port_pkg::MST_RUN) || (s_ff.bits != spi_port_pkg::BIT_ZERO);
      edge_num = s_ff.edges + 5'h01;

      // software writes; flags may only be cleared this way
      if (ctrl_wr_i) begin
         nxt_s.write_collision_flag = s_ff.write_collision_flag & ctrl_wdata_i[spi_port_pkg::CTL_WRITE_COLLISION_FLAG];
         nxt_s.ovfl = s_ff.ovfl & ctrl_wdata_i[spi_port_pkg::CTL_OVFL];
         nxt_s.en = ctrl_wdata_i[spi_port_pkg::CTL_EN];
         nxt_s.clock_polarity_bit = ctrl_wdata_i[spi_port_pkg::CTL_CKP];
         nxt_s.mode = ctrl_wdata_i[3:0];
      end
      if (status_wr_i) begin
         nxt_s.sample_phase_bit = status_wdata_i[spi_port_pkg::STA_SMP];
         nxt_s.cke = status_wdata_i[spi_port_pkg::STA_CKE];
      end
      if (buf_rd_i) begin
         nxt_s.full = 1'b0;
      end
      if (irq_clr_i) begin
         nxt_s.irq = 1'b0;
      end

      // serial clock edges, from the divider or from the pin
      nxt_s.sck_prev = sck_i;
      if (is_master) begin
         edge_ev = tick && (s_ff.mst == spi_port_pkg::MST_RUN);
         lead = (s_ff.sck == s_ff.clock_polarity_bit);
      end else begin
         // unselected slave sees no edges at all
         edge_ev = is_slave && selected && (sck_i != s_ff.sck_prev);
         lead = (s_ff.sck_prev == s_ff.clock_polarity_bit);
      end
      sample_edge = (lead == s_ff.cke);
      if (is_master && s_ff.sample_phase_bit) begin
         // late sampling moves the capture onto the following output edge
         do_shift = edge_ev && ((!sample_edge && s_ff.edges != spi_port_pkg::EDGE_ZERO) ||
                                edge_num == spi_port_pkg::EDGE_LAST);
      end else begin
         do_shift = edge_ev && sample_edge;
      end
      byte_done = do_shift && (s_ff.bits == spi_port_pkg::BIT_LAST);

      if (do_shift) begin
         nxt_s.shreg = {s_ff.shreg[6:0], sdi_i};
         nxt_s.bits = s_ff.bits + 3'h1; // wraps to zero after eight
      end
      if (edge_ev && !sample_edge) begin
         nxt_s.sdo = nxt_s.shreg[7];
      end
      if (is_master && edge_ev) begin
         nxt_s.sck = ~s_ff.sck;
         nxt_s.edges = edge_num;
         if (edge_num == spi_port_pkg::EDGE_LAST) begin
            nxt_s.mst = spi_port_pkg::MST_IDLE; // clock parks at idle
            nxt_s.edges = spi_port_pkg::EDGE_ZERO;
         end
      end

      // byte complete; the set wins over a same-cycle read or clear
      if (byte_done) begin
         nxt_s.irq = 1'b1;
         if (!s_ff.full || buffer_overwrite_enable_i) begin
            nxt_s.dbuf = nxt_s.shreg;
            nxt_s.full = 1'b1;
         end else begin
            // old byte is kept; buffer-full stays set unless read in this same cycle
            nxt_s.ovfl = 1'b1;
         end
      end

      // buffer write: loads shifter and buffer together
      wr_ok = s_ff.en && !busy && !s_ff.write_collision_flag && (!s_ff.full || buffer_overwrite_enable_i);
      if (buf_wr_i && s_ff.en) begin
         if (wr_ok) begin
            nxt_s.shreg = buf_wdata_i;
            nxt_s.dbuf = buf_wdata_i;
            nxt_s.sdo = buf_wdata_i[7]; // valid ahead of the first edge
            if (is_master) begin
               nxt_s.mst = spi_port_pkg::MST_RUN;
               nxt_s.edges = spi_port_pkg::EDGE_ZERO;
            end
         end else begin
            nxt_s.write_collision_flag = 1'b1;
         end
      end

      // port resets: select released or enable cleared
      if (s_ff.en && s_ff.mode == spi_port_pkg::MODE_SLAVE_SEL && sel_n_i) begin
         nxt_s.bits = spi_port_pkg::BIT_ZERO;
      end
      if (!s_ff.en) begin
         nxt_s.bits = spi_port_pkg::BIT_ZERO;
         nxt_s.mst = spi_port_pkg::MST_IDLE;
         nxt_s.edges = spi_port_pkg::EDGE_ZERO;
      end
      if (nxt_s.mst == spi_port_pkg::MST_IDLE) begin
         nxt_s.sck = nxt_s.clock_polarity_bit;
      end

      // pin ownership
      nxt_s.sck_oe = is_master;
      nxt_s.sdo_oe = is_master || (is_slave && selected);
   end

   // -------------------------------------------------------------------
   // state register
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         s_ff <= '{mst: spi_port_pkg::MST_IDLE, shreg: spi_port_pkg::BYTE_ZERO,
                   dbuf: spi_port_pkg::BYTE_ZERO, bits: spi_port_pkg::BIT_ZERO,
                   edges: spi_port_pkg::EDGE_ZERO, mode: spi_port_pkg::MODE_DIV4,
                   default: 1'b0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   // -------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------
   assign sck_o = s_ff.sck;
   assign sck_oe_o = s_ff.sck_oe;
   assign sdo_o = s_ff.sdo;
   assign sdo_oe_o = s_ff.sdo_oe;
   assign data_buffer_o = s_ff.dbuf;
   assign port_interrupt_flag_o = s_ff.irq;
   assign port_control_one_o = {s_ff.write_collision_flag, s_ff.ovfl, s_ff.en, s_ff.clock_polarity_bit, s_ff.mode};
   // low six bits are read-only; only buffer-full is live
   assign port_status_reg_o = {s_ff.sample_phase_bit, s_ff.cke, spi_port_pkg::STA_RO_ZERO,
                               s_ff.full};

endmodule // sync_serial_port

`default_nettype wire

// file: test/spi_port_asserts.sv
// checker for the serial port's pins and flags, bound to the design top
// assumes one system clock domain and an active-high reset
`timescale 1ns/1ps
`default_nettype none
module spi_port_asserts (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic ctrl_wr_i,
   input wire logic [7:0] ctrl_wdata_i,
   input wire logic status_wr_i,
   input wire logic [7:0] status_wdata_i,
   input wire logic buf_wr_i,
   input wire logic buf_rd_i,
   input wire logic irq_clr_i,
   input wire logic sel_n_i,
   input wire logic sck_o,
   input wire logic sck_oe_o,
   input wire logic sdo_oe_o,
   input wire logic [7:0] port_control_one_o,
   input wire logic [7:0] port_status_reg_o,
   input wire logic port_interrupt_flag_o
);
   // -------------------------------------------------------------
   // flag and pin relations
   // -------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   logic en, full, write_collision_flag, sel_mode;
   assign en = port_control_one_o[5];
   assign full = port_status_reg_o[0];
   assign write_collision_flag = port_control_one_o[7];
   assign sel_mode = port_control_one_o[3:0] == spi_port_pkg::MODE_SLAVE_SEL;
   // fastest rate, idle low: the first toggle must land within a few clocks
   sequence s_idle_write;
      buf_wr_i && en && !write_collision_flag && !full && !sck_o && port_control_one_o[4:0] == 5'h00;
   endsequence
   sequence s_clock_out;
      ##[1:6] sck_o;
   endsequence
   a_start_on_write: assert property (s_idle_write |-> s_clock_out)
      else $error("master clock did not start after buffer write");
   a_busy_write_coll: assert property (
      buf_wr_i && en && sck_oe_o && sck_o != port_control_one_o[4] |=> write_collision_flag)
      else $error("write during transfer did not flag a collision");
   a_coll_stays: assert property (write_collision_flag && !(ctrl_wr_i && !ctrl_wdata_i[7]) |=> write_collision_flag)
      else $error("collision flag cleared without software");
   a_irq_stays: assert property (port_interrupt_flag_o && !irq_clr_i |=> port_interrupt_flag_o)
      else $error("interrupt flag dropped on its own");
   a_full_stays: assert property (full && !buf_rd_i |=> full)
      else $error("buffer-full dropped without a read");
   a_read_clears: assert property (buf_rd_i ##1 !$rose(port_interrupt_flag_o) |-> !full)
      else $error("buffer read left buffer-full set");
   a_status_low_ro: assert property (port_status_reg_o[5:1] == spi_port_pkg::STA_RO_ZERO)
      else $error("read-only status bits not zero");
   a_status_upper_rw: assert property (
      status_wr_i |=> port_status_reg_o[7:6] == $past(status_wdata_i[7:6]))
      else $error("status upper bits did not take the write");
   a_off_no_drive: assert property (!en [*2] |-> !sck_oe_o && !sdo_oe_o)
      else $error("disabled port drives a pin");
   a_unsel_quiet: assert property ((en && sel_mode && sel_n_i) [*2] |-> !sdo_oe_o)
      else $error("unselected slave drives data out");
endmodule // spi_port_asserts
bind sync_serial_port spi_port_asserts chk_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
   .ctrl_wr_i(ctrl_wr_i), .ctrl_wdata_i(ctrl_wdata_i), .status_wr_i(status_wr_i),
   .status_wdata_i(status_wdata_i), .buf_wr_i(buf_wr_i), .buf_rd_i(buf_rd_i),
   .irq_clr_i(irq_clr_i), .sel_n_i(sel_n_i), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
   .sdo_oe_o(sdo_oe_o), .port_control_one_o(port_control_one_o),
   .port_status_reg_o(port_status_reg_o), .port_interrupt_flag_o(port_interrupt_flag_o));
`default_nettype wire

// file: test/spi_remote.sv
// remote slave for master-mode runs, clock idle low, change lead, sample trail
// assumes sck edges at least two system clocks apart
`timescale 1ns/1ps
`default_nettype none
module spi_remote (
   input wire logic clk_i,
   input wire logic sck_i,
   input wire logic sel_n_i,
   input wire logic mosi_i,
   input wire logic [7:0] load_i,
   input wire logic load_en_i,
   output logic miso_o,
   output logic [7:0] shreg_o
);
   // -------------------------------------------------------------
   // shifter
   // -------------------------------------------------------------
   logic sck_q = 1'b0;
   logic drv = 1'b0;
   logic tgl = 1'b0;
   always @(posedge clk_i) begin
      sck_q <= sck_i;
      tgl <= ~tgl;
      if (load_en_i)
         shreg_o <= load_i;
      else if (!sel_n_i && sck_q && !sck_i)
         shreg_o <= {shreg_o[6:0], mosi_i};
      if (!sck_q && sck_i)
         drv <= shreg_o[7];
   end
   // released line wanders so a stale bit is never mistaken for data
   assign miso_o = sel_n_i ? tgl : drv;
endmodule // spi_remote
`default_nettype wire

// file: test/tb_top.sv
// bench for the serial port: rates, exchange, collision, slave select
// assumes spi_remote as far-end slave and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // -------------------------------------------------------------
   // stimulus and scenarios
   // -------------------------------------------------------------
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic ctrl_wr_i = 1'b0, status_wr_i = 1'b0, buf_wr_i = 1'b0, buf_rd_i = 1'b0;
   logic irq_clr_i = 1'b0, ovw = 1'b0, tmatch = 1'b0, m_sck = 1'b0, m_sdi = 1'b0;
   logic sel_n = 1'b1, rsel_n = 1'b1, rload = 1'b0;
   logic [7:0] ctrl_wdata_i = 8'h00, status_wdata_i = 8'h00, buf_wdata_i = 8'h00;
   logic [7:0] rbyte = 8'h00, ctl, sta, dbuf, rsh;
   logic sck_o, sck_oe_o, sdo_o, sdo_oe_o, irq, miso, sck, sdi;
   int err_count = 0, compares = 0, cyc = 0, tcnt = 0;
   assign sck = sck_oe_o ? sck_o : m_sck;
   assign sdi = sck_oe_o ? miso : m_sdi;
   sync_serial_port dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ctrl_wr_i(ctrl_wr_i),
      .ctrl_wdata_i(ctrl_wdata_i), .status_wr_i(status_wr_i), .status_wdata_i(status_wdata_i),
      .buf_wr_i(buf_wr_i), .buf_wdata_i(buf_wdata_i), .buf_rd_i(buf_rd_i), .irq_clr_i(irq_clr_i),
      .buffer_overwrite_enable_i(ovw), .baud_reload_value_i(8'h02), .timer_match_i(tmatch),
      .sck_i(sck), .sdi_i(sdi), .sel_n_i(sel_n), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
      .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .port_control_one_o(ctl),
      .port_status_reg_o(sta), .data_buffer_o(dbuf), .port_interrupt_flag_o(irq));
   spi_remote rem (.clk_i(clk_sys_i), .sck_i(sck), .sel_n_i(rsel_n), .mosi_i(sdo_o),
      .load_i(rbyte), .load_en_i(rload), .miso_o(miso), .shreg_o(rsh));
   initial forever #5 clk_sys_i = ~clk_sys_i;
   always @(negedge clk_sys_i) begin
      tcnt <= (tcnt == 4) ? 0 : tcnt + 1;
      tmatch <= (tcnt == 4);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         close_out();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // k picks the strobe: 0 control, 1 status, 2 buffer write, 3 read, 4 irq clear
   task automatic op(input int k, input logic [7:0] d);
      @(negedge clk_sys_i);
      ctrl_wdata_i = d;
      status_wdata_i = d;
      buf_wdata_i = d;
      {ctrl_wr_i, status_wr_i, buf_wr_i, buf_rd_i, irq_clr_i} = 5'h10 >> k;
      @(negedge clk_sys_i);
      {ctrl_wr_i, status_wr_i, buf_wr_i, buf_rd_i, irq_clr_i} = 5'h00;
   endtask
   task automatic wait_irq(output int hi);
      hi = 0;
      for (int i = 0; i < 2000 && irq !== 1'b1; i++) begin
         @(negedge clk_sys_i);
         hi += int'(sck_o === 1'b1);
      end
   endtask
   task automatic mx(input logic [3:0] m, input logic [7:0] tx, rx, input int hx);
      int hi;
      op(0, 8'h00); // off before reconfiguring
      op(0, {4'h2, m});
      rbyte = rx;
      rload = 1'b1;
      op(4, 8'h00);
      rload = 1'b0;
      rsel_n = 1'b0;
      op(2, tx);
      wait_irq(hi);
      repeat (4) @(negedge clk_sys_i);
      rsel_n = 1'b1;
      chk(16'(hi), 16'(hx));
      chk(16'({sta[0], dbuf}), {8'h01, rx});
      chk(16'(rsh), 16'(tx));
   endtask
   task automatic t_master;
      logic [3:0] md [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'ha};
      int hx [5] = '{16, 64, 256, 40, 48};
      int hi;
      for (int i = 0; i < 5; i++) begin
         op(3, 8'h00);
         mx(md[i], 8'ha5 ^ 8'(i), 8'h3c + 8'(i), hx[i]);
      end
      op(1, 8'hff);
      chk(16'(sta), 16'h00c1);
      op(1, 8'h00);
      op(3, 8'h00);
      op(0, 8'h21);
      op(4, 8'h00);
      rsel_n = 1'b0;
      op(2, 8'h5a);
      while (sck_o !== 1'b1) @(negedge clk_sys_i);
      op(2, 8'hff);
      chk(16'(ctl[7]), 16'h0001);
      wait_irq(hi);
      op(2, 8'h11);
      repeat (40) @(negedge clk_sys_i);
      chk(16'({rsh, dbuf}), 16'h5aa1);
      op(0, 8'h21);
      op(2, 8'h22);
      chk(16'({ctl[7], sta[0]}), 16'h0003);
      op(0, 8'h21);
      ovw = 1'b1;
      mx(4'h0, 8'h77, 8'h88, 16);
      ovw = 1'b0;
      op(3, 8'h00);
      chk(16'(sta[0]), 16'h0000);
   endtask
   task automatic sbyte(input logic [7:0] d, input int n, output logic [7:0] got);
      got = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         m_sdi = d[i];
         m_sck = 1'b1;
         repeat (4) @(negedge clk_sys_i);
         got = {got[6:0], sdo_o};
         m_sck = 1'b0;
         repeat (4) @(negedge clk_sys_i);
      end
   endtask
   task automatic t_slave;
      logic [7:0] g;
      op(0, 8'h00);
      op(4, 8'h00);
      m_sck = 1'b0;
      op(0, 8'h24);
      op(2, 8'h69);
      sbyte(8'hff, 3, g);
      chk(16'({irq, sdo_oe_o}), 16'h0000);
      sel_n = 1'b0;
      repeat (2) @(negedge clk_sys_i);
      chk(16'(sdo_oe_o), 16'h0001);
      sbyte(8'h96, 8, g);
      chk(16'(g), 16'h0069);
      chk(16'({irq, dbuf}), 16'h0196);
      op(3, 8'h00);
      sbyte(8'hf0, 3, g);
      sel_n = 1'b1;
      repeat (2) @(negedge clk_sys_i);
      chk(16'(sdo_oe_o), 16'h0000);
      sel_n = 1'b0;
      sbyte(8'h3c, 8, g);
      chk(16'(dbuf), 16'h003c);
      op(0, 8'h00);
      op(0, 8'h25);
      op(3, 8'h00);
      op(4, 8'h00);
      sbyte(8'h81, 8, g);
      chk(16'({irq, dbuf}), 16'h0181);
      op(1, 8'h40);
      op(0, 8'h00);
      op(0, 8'h24);
      op(3, 8'h00);
      op(4, 8'h00);
      op(2, 8'hc3);
      sbyte(8'h5e, 8, g);
      chk(16'({g, dbuf}), 16'hc35e);
      sel_n = 1'b1;
   endtask
   task automatic close_out;
      if (err_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      rst_i = 1'b0;
      chk(16'({ctl, sta}), 16'h0000);
      chk(16'({irq, sck_oe_o, sdo_oe_o}), 16'h0000);
      t_master();
      t_slave();
      close_out();
   end
endmodule // tb_top
`default_nettype wire
